// file: include/dsw_defines.svh
/*
 * Constants shared by both ends of the DAC serial write port: timing figures,
 * word layout and the controller's register map.
 * Assumes a 100 MHz system clock on both ends.
 */
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH

// Timing figures in their own units and the cycle counts derived from them.
`define DSW_CLK_NS        10
`define DSW_SCLK_MAX_MHZ  30
`define DSW_SCLK_MIN_NS   ((1000 + `DSW_SCLK_MAX_MHZ - 1) / `DSW_SCLK_MAX_MHZ)
`define DSW_SYNC_GAP_NS   12
`define DSW_SYNC_GAP_CYC  ((`DSW_SYNC_GAP_NS + `DSW_CLK_NS - 1) / `DSW_CLK_NS)
`define DSW_HALF_DEFAULT  8

// Word layout.
`define DSW_WORD_LONG     24
`define DSW_WORD_SHORT    16
`define DSW_DATA_LONG     16
`define DSW_DATA_SHORT    14
`define DSW_MODE_NORMAL   2'h0
`define DSW_MODE_SOFTRST  2'h3
`define DSW_CODE_ZERO     16'h0000
`define DSW_MID_LONG      16'h8000
`define DSW_MID_SHORT     16'h2000

// Controller register map, byte addresses of 32-bit words.
`define DSW_REG_CTRL      4'h0
`define DSW_REG_WORD      4'h4
`define DSW_REG_STATUS    4'h8
`define DSW_CTRL_START    0
`define DSW_CTRL_ABORT    1
`define DSW_CTRL_IDLELOW  2
`define DSW_STAT_BUSY     0
`define DSW_STAT_DONE     1

`endif

// file: include/dsw_pkg.sv
/*
 * Types for the DAC serial write port.
 * Assumes dsw_defines.svh is on the include path.
 */
package dsw_pkg;
    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_SHIFT,
        DEV_DONE
    } dsw_dev_state_type;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_GAP,
        HST_HIGH,
        HST_LOW
    } dsw_host_state_type;

    typedef logic [1:0] dsw_mode_type;
endpackage : dsw_pkg

// file: include/dsw_if.sv
/*
 * The three wires between the host controller and the DAC input port.
 * Assumes the host drives all three wires; the device only listens.
 */
interface dsw_if;
    logic sclk;
    logic sync_n;
    logic sdin;

    modport host (
        output sclk,
        output sync_n,
        output sdin
    );

    modport device (
        input sclk,
        input sync_n,
        input sdin
    );
endinterface : dsw_if

// file: hw/dsw_device.sv
/*
 * Device end of the DAC serial write port: input shift register, command
 * execution, DAC register with power-on code and the switch decode.
 * Assumes the link wires come from another clock domain and that the
 * serial clock is slow enough to be sampled by the 100 MHz clock.
 */
`include "dsw_defines.svh"

module dsw_device #(
    parameter int WORD_BITS    = `DSW_WORD_LONG,
    parameter bit POR_MIDSCALE = 1'b1
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    dsw_if.device                 link,
    output logic [15:0]           dac_code_o,
    output dsw_pkg::dsw_mode_type mode_o,
    output logic [14:0]           segment_o,
    output logic [11:0]           ladder_o,
    output logic                  frame_done_o,
    output logic                  frame_abort_o
);
    import dsw_pkg::*;

    localparam int DATA_BITS = (WORD_BITS == `DSW_WORD_LONG) ? `DSW_DATA_LONG
                                                             : `DSW_DATA_SHORT;
    localparam int ALIGN = 16 - DATA_BITS;

    if (WORD_BITS != `DSW_WORD_LONG && WORD_BITS != `DSW_WORD_SHORT) begin : g_bad_word
        $error("dsw_device: WORD_BITS must be 24 or 16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [15:0] por_code();
        if (!POR_MIDSCALE) begin
            return `DSW_CODE_ZERO;
        end
        return (WORD_BITS == `DSW_WORD_LONG) ? `DSW_MID_LONG : `DSW_MID_SHORT;
    endfunction : por_code

    function automatic logic [14:0] seg_decode(input logic [3:0] msb);
        logic [14:0] seg;
        seg = 15'h0000;
        for (int i = 0; i < 15; i++) begin
            seg[i] = (msb > 4'(i));
        end
        return seg;
    endfunction : seg_decode

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Stage 0 feeds only stage 1; edges are taken
    // between stage 1 and a third flop so no logic sees a metastable value.

    logic [1:0] sclk_sync;
    logic [1:0] fsync_sync;
    logic [1:0] din_sync;
    logic       sclk_prev;
    logic       fsync_prev;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sclk_sync  <= 2'h3;
            fsync_sync <= 2'h3;
            din_sync   <= 2'h0;
            sclk_prev  <= 1'b1;
            fsync_prev <= 1'b1;
        end else begin
            sclk_sync  <= {sclk_sync[0], link.sclk};
            fsync_sync <= {fsync_sync[0], link.sync_n};
            din_sync   <= {din_sync[0], link.sdin};
            sclk_prev  <= sclk_sync[1];
            fsync_prev <= fsync_sync[1];
        end
    end

    logic sclk_fall;
    logic fsync_fall;
    logic fsync_high;

    assign sclk_fall  = sclk_prev & ~sclk_sync[1];
    assign fsync_fall = fsync_prev & ~fsync_sync[1];
    assign fsync_high = fsync_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencing.

    dsw_dev_state_type    state;
    logic [WORD_BITS-1:0] shreg;
    logic [4:0]           bit_count;
    logic                 last_edge;
    logic [WORD_BITS-1:0] word;

    assign last_edge = sclk_fall && (bit_count == 5'(WORD_BITS - 1));
    assign word      = {shreg[WORD_BITS-2:0], din_sync[1]};

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state <= DEV_IDLE;
        end else begin
            case (state)
                DEV_IDLE: begin
                    if (fsync_fall) begin
                        state <= DEV_SHIFT;
                    end
                end
                DEV_SHIFT: begin
                    // Sync high wins over a clock edge seen in the same cycle.
                    if (fsync_high) begin
                        state <= DEV_IDLE;
                    end else if (last_edge) begin
                        state <= DEV_DONE;
                    end
                end
                DEV_DONE: begin
                    if (fsync_high) begin
                        state <= DEV_IDLE;
                    end
                end
                default: begin
                    state <= DEV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            shreg     <= '0;
            bit_count <= 5'h00;
        end else if (state != DEV_SHIFT || fsync_high) begin
            shreg     <= '0;
            bit_count <= 5'h00;
        end else if (sclk_fall) begin
            shreg     <= word;
            bit_count <= bit_count + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command execution on the final falling edge.

    logic         execute;
    dsw_mode_type mode_bits;
    logic [15:0]  data_bits;
    logic         soft_reset;

    assign execute   = (state == DEV_SHIFT) && !fsync_high && last_edge;
    assign mode_bits = word[DATA_BITS+1:DATA_BITS];
    assign data_bits = 16'(word[DATA_BITS-1:0]);

    // The long word resets only when all ones; the short word has no spare
    // bits, so its reset code is the mode pair alone.
    assign soft_reset = (WORD_BITS == `DSW_WORD_LONG) ? (&word)
                                                      : (mode_bits == `DSW_MODE_SOFTRST);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dac_code_o <= por_code();
            mode_o     <= `DSW_MODE_NORMAL;
        end else if (execute) begin
            if (soft_reset) begin
                dac_code_o <= por_code();
                mode_o     <= `DSW_MODE_NORMAL;
            end else if (mode_bits == `DSW_MODE_NORMAL) begin
                dac_code_o <= data_bits;
                mode_o     <= mode_bits;
            end else begin
                mode_o     <= mode_bits;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            frame_done_o  <= 1'b0;
            frame_abort_o <= 1'b0;
        end else begin
            frame_done_o  <= execute;
            frame_abort_o <= (state == DEV_SHIFT) && fsync_high;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Switch decode. It lags the DAC register by one cycle so that every
    // output stays a plain flop.

    logic [15:0] aligned;

    assign aligned = dac_code_o << ALIGN;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            segment_o <= '0;
            ladder_o  <= '0;
        end else begin
            segment_o <= seg_decode(aligned[15:12]);
            ladder_o  <= aligned[11:0];
        end
    end
endmodule : dsw_device

// file: hw/dsw_host.sv
/*
 * Host end of the DAC serial write port: a register-driven controller that
 * derives the serial clock by a divider and sends one word per command.
 * Assumes software reaches it through the plain register port.
 */
`include "dsw_defines.svh"

module dsw_host #(
    parameter int WORD_BITS = `DSW_WORD_LONG,
    parameter int HALF_DIV  = `DSW_HALF_DEFAULT
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    dsw_if.host              link
);
    import dsw_pkg::*;

    if (WORD_BITS != `DSW_WORD_LONG && WORD_BITS != `DSW_WORD_SHORT) begin : g_bad_word
        $error("dsw_host: WORD_BITS must be 24 or 16");
    end
    // Too small a divider would push the serial clock past its limit.
    if (2 * HALF_DIV * `DSW_CLK_NS < `DSW_SCLK_MIN_NS || HALF_DIV > 255) begin : g_bad_div
        $error("dsw_host: HALF_DIV out of range");
    end

    localparam logic [7:0] HALF_CNT = 8'(HALF_DIV - 1);
    localparam logic [7:0] GAP_CNT  = 8'(`DSW_SYNC_GAP_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    dsw_host_state_type   state;
    logic [WORD_BITS-1:0] word_reg;
    logic [WORD_BITS-1:0] tx_shift;
    logic                 idle_low;
    logic                 done;
    logic [7:0]           timer;
    logic [4:0]           bit_count;
    logic                 start_req;
    logic                 abort_req;
    logic                 finish;

    assign start_req = wr_i && addr_i == `DSW_REG_CTRL && wdata_i[`DSW_CTRL_START];
    assign abort_req = wr_i && addr_i == `DSW_REG_CTRL && wdata_i[`DSW_CTRL_ABORT];
    assign finish    = state == HST_LOW && timer == 8'h00
                       && bit_count == 5'(WORD_BITS - 1);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            word_reg <= '0;
            idle_low <= 1'b0;
        end else if (wr_i && addr_i == `DSW_REG_WORD) begin
            word_reg <= wdata_i[WORD_BITS-1:0];
        end else if (wr_i && addr_i == `DSW_REG_CTRL) begin
            idle_low <= wdata_i[`DSW_CTRL_IDLELOW];
        end
    end

    // A finishing frame sets the done flag even if a start clears it.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            done <= 1'b0;
        end else if (finish) begin
            done <= 1'b1;
        end else if (start_req && state == HST_IDLE) begin
            done <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                `DSW_REG_CTRL:   rdata_o <= {29'h0, idle_low, 2'h0};
                `DSW_REG_WORD:   rdata_o <= 32'(word_reg);
                `DSW_REG_STATUS: rdata_o <= {30'h0, done, state != HST_IDLE};
                default:         rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame generator. Data changes on the rising serial edge so it is
    // stable at the falling edge where the device samples it.

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state       <= HST_IDLE;
            timer       <= 8'h00;
            bit_count   <= 5'h00;
            tx_shift    <= '0;
            link.sclk   <= 1'b1;
            link.sync_n <= 1'b1;
            link.sdin   <= 1'b0;
        end else if (abort_req && (state == HST_HIGH || state == HST_LOW)) begin
            state       <= HST_IDLE;
            link.sclk   <= 1'b1;
            link.sync_n <= 1'b1;
        end else begin
            timer <= (timer == 8'h00) ? 8'h00 : timer - 8'h01;
            case (state)
                HST_IDLE: begin
                    link.sync_n <= ~idle_low;
                    if (start_req) begin
                        state       <= HST_GAP;
                        timer       <= GAP_CNT;
                        link.sync_n <= 1'b1;
                    end
                end
                HST_GAP: begin
                    if (timer == 8'h00) begin
                        state       <= HST_HIGH;
                        timer       <= HALF_CNT;
                        bit_count   <= 5'h00;
                        tx_shift    <= word_reg << 1;
                        link.sdin   <= word_reg[WORD_BITS-1];
                        link.sync_n <= 1'b0;
                    end
                end
                HST_HIGH: begin
                    if (timer == 8'h00) begin
                        state     <= HST_LOW;
                        timer     <= HALF_CNT;
                        link.sclk <= 1'b0;
                    end
                end
                HST_LOW: begin
                    if (finish) begin
                        state       <= HST_IDLE;
                        link.sclk   <= 1'b1;
                        link.sync_n <= ~idle_low;
                    end else if (timer == 8'h00) begin
                        state     <= HST_HIGH;
                        timer     <= HALF_CNT;
                        bit_count <= bit_count + 5'h01;
                        tx_shift  <= tx_shift << 1;
                        link.sclk <= 1'b1;
                        link.sdin <= tx_shift[WORD_BITS-1];
                    end
                end
                default: begin
                    state <= HST_IDLE;
                end
            endcase
        end
    end
endmodule : dsw_host

// file: verification/dsw_asserts.sv
/*
 * Concurrent checks on the three link wires between the two ends.
 * Assumes it is instantiated beside the interface, on the 100 MHz clock.
 */
`include "dsw_defines.svh"

module dsw_asserts #(
    parameter int WORD_BITS = `DSW_WORD_LONG
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdin_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic     sclk_q;
    int       falls;

    ////////////////////////////////////////////////////////////////////////////////
    // Falls are counted per frame; the count is held at zero while sync is high or in reset.
    always_ff @(posedge clock_i) begin
        sclk_q <= sclk_i;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || sync_n_i) begin
            falls <= 0;
        end else if (sclk_q && !sclk_i) begin
            falls <= falls + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    chk_sync_gap: assert property ($rose(sync_n_i) |=> sync_n_i)
        else $error("sync high for less than two cycles");
    chk_frame_open: assert property (
        $fell(sync_n_i) |-> sclk_i && $past(sync_n_i, 2))
        else $error("frame opened without clock high and gap");
    chk_idle_clock: assert property (sync_n_i |-> sclk_i)
        else $error("serial clock low outside a frame");
    chk_fall_framed: assert property ($fell(sclk_i) |-> !sync_n_i)
        else $error("serial clock fell outside a frame");
    chk_data_hold: assert property (!sync_n_i && !sclk_i |-> $stable(sdin_i))
        else $error("serial data moved while clock low");
    chk_high_phase: assert property ($rose(sclk_i) && !sync_n_i |=> sclk_i)
        else $error("serial clock high phase too short");
    chk_low_phase: assert property ($fell(sclk_i) |=> !sclk_i || sync_n_i)
        else $error("serial clock low phase too short");
    chk_fall_limit: assert property (falls <= WORD_BITS)
        else $error("more falling edges than a word holds");
endmodule : dsw_asserts

// file: verification/test_dac_serial_write_port.sv
/*
 * Testbench: host controller and device joined by the link interface,
 * driven through the host register port, device outputs compared.
 * Assumes a long word pair and a short word pair, each with a fast host divider.
 */
`include "dsw_defines.svh"

module test_dac_serial_write_port;
    timeunit 1ns;
    timeprecision 1ps;
    import dsw_pkg::*;

    logic               clock_i;
    logic               rst_i;
    logic [3:0]         addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
    logic [31:0]        rdata;
    logic [15:0]        dac_code;
    dsw_mode_type       mode;
    logic [14:0]        seg;
    logic [11:0]        lad;
    logic               done_p;
    logic               abort_p;
    int                 err_total;
    int                 samples_checked;
    int                 cycles;
    int                 n_done;
    int                 n_abort;
    logic [31:0]        got;
    logic [23:0]        t_word [8] = '{24'h00FFFF, 24'h000000, 24'h001234, 24'h015555,
                                       24'h025555, 24'h035555, 24'hFCABCD, 24'hFFFFFF};
    logic [15:0]        t_code [8] = '{16'hFFFF, 16'h0000, 16'h1234, 16'h1234,
                                       16'h1234, 16'h1234, 16'hABCD, 16'h8000};
    logic [1:0]         t_mode [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    logic [15:0]        code_s;
    dsw_mode_type       mode_s;
    logic [14:0]        seg_s;
    logic [11:0]        lad_s;
    logic [15:0]        t_scode [8] = '{16'h0000, 16'h0000, 16'h1234, 16'h1234,
                                        16'h1234, 16'h1234, 16'h1234, 16'h0000};
    logic [1:0]         t_smode [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0};

    dsw_if link_if();
    dsw_if short_if();

    dsw_host #(.WORD_BITS(24), .HALF_DIV(2)) dsw_host_inst (
        .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link_if.host));

    dsw_device #(.WORD_BITS(24), .POR_MIDSCALE(1'b1)) dsw_device_inst (
        .clock_i(clock_i), .rst_i(rst_i), .link(link_if.device), .dac_code_o(dac_code),
        .mode_o(mode), .segment_o(seg), .ladder_o(lad), .frame_done_o(done_p),
        .frame_abort_o(abort_p));

    dsw_asserts #(.WORD_BITS(24)) dsw_asserts_inst (
        .clock_i(clock_i), .rst_i(rst_i), .sclk_i(link_if.sclk),
        .sync_n_i(link_if.sync_n), .sdin_i(link_if.sdin));

    // The short pair shares the register bus, so it always sends the low half of each word.
    dsw_host #(.WORD_BITS(16), .HALF_DIV(2)) dsw_host_short_inst (
        .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(), .link(short_if.host));

    dsw_device #(.WORD_BITS(16), .POR_MIDSCALE(1'b0)) dsw_device_short_inst (
        .clock_i(clock_i), .rst_i(rst_i), .link(short_if.device), .dac_code_o(code_s),
        .mode_o(mode_s), .segment_o(seg_s), .ladder_o(lad_s), .frame_done_o(),
        .frame_abort_o());

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (done_p === 1'b1) n_done <= n_done + 1;
        if (abort_p === 1'b1) n_abort <= n_abort + 1;
        if (cycles == 8000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Waits on the device's own pulse, since the host goes idle one cycle earlier.
    task automatic send(input logic [23:0] w, input logic idle_low);
        int k;
        k = n_done;
        wr_reg(`DSW_REG_WORD, {8'h00, w});
        wr_reg(`DSW_REG_CTRL, {29'h0, idle_low, 2'b01});
        for (int i = 0; i < 600 && n_done == k; i++) @(posedge clock_i);
        @(posedge clock_i);
        #1 check("frame done", 32'(n_done != k), 32'h1);
    endtask : send

    task automatic chk_dev(input logic [15:0] c, input logic [1:0] m);
        logic [14:0] t;
        for (int i = 0; i < 15; i++) t[i] = (c[15:12] > i);
        check("dac code", {16'h0, dac_code}, {16'h0, c});
        check("mode", {30'h0, mode}, {30'h0, m});
        check("segment", {17'h0, seg}, {17'h0, t});
        check("ladder", {20'h0, lad}, {20'h0, c[11:0]});
    endtask : chk_dev

    // The short code is left-aligned by two bits before it reaches the switches.
    task automatic chk_short(input logic [15:0] c, input logic [1:0] m);
        logic [15:0] a;
        logic [14:0] t;
        a = c << 2;
        for (int i = 0; i < 15; i++) t[i] = (a[15:12] > i);
        check("short code", {16'h0, code_s}, {16'h0, c});
        check("short mode", {30'h0, mode_s}, {30'h0, m});
        check("short segment", {17'h0, seg_s}, {17'h0, t});
        check("short ladder", {20'h0, lad_s}, {20'h0, a[11:0]});
    endtask : chk_short

    task automatic finish_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        n_done = 0;
        n_abort = 0;
        rst_i = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1 chk_dev(16'h8000, 2'h0);
        chk_short(16'h0000, 2'h0);
        rd_reg(4'hC, got);
        check("unmapped read", got, 32'h0);
        wr_reg(`DSW_REG_WORD, 32'hFFFFFFFF);
        wr_reg(4'hC, 32'h0);
        rd_reg(`DSW_REG_WORD, got);
        check("word register", got, 32'h00FFFFFF);
        for (int i = 0; i < 8; i++) begin
            send(t_word[i], 1'b0);
            chk_dev(t_code[i], t_mode[i]);
            chk_short(t_scode[i], t_smode[i]);
        end
        rd_reg(`DSW_REG_STATUS, got);
        check("status done", got, 32'h2);
        // A frame cut short in its middle must leave the code, mode and switch outputs alone.
        k = n_abort;
        wr_reg(`DSW_REG_WORD, 32'h00001111);
        wr_reg(`DSW_REG_CTRL, 32'h1);
        repeat (30) @(posedge clock_i);
        wr_reg(`DSW_REG_CTRL, 32'h2);
        for (int i = 0; i < 100 && n_abort == k; i++) @(posedge clock_i);
        repeat (4) @(posedge clock_i);
        #1 check("abort seen", 32'(n_abort != k), 32'h1);
        chk_dev(16'h8000, 2'h0);
        chk_short(16'h0000, 2'h0);
        rd_reg(`DSW_REG_STATUS, got);
        check("status after abort", got, 32'h0);
        send(24'h004321, 1'b1);
        check("sync idles low", {31'h0, link_if.sync_n}, 32'h0);
        rd_reg(`DSW_REG_CTRL, got);
        check("idle low bit", got, 32'h4);
        chk_dev(16'h4321, 2'h0);
        chk_short(16'h0000, 2'h1);
        send(24'h00BEEF, 1'b0);
        chk_dev(16'hBEEF, 2'h0);
        chk_short(16'h0000, 2'h2);
        check("sync idles high", {31'h0, link_if.sync_n}, 32'h1);
        send(24'h003FFF, 1'b0);
        chk_dev(16'h3FFF, 2'h0);
        chk_short(16'h3FFF, 2'h0);
        finish_test();
    end
endmodule : test_dac_serial_write_port
